// [design/two_wire_slave_port.sv]
`timescale 1ns/1ps
`default_nettype none

module two_wire_slave_port (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clk_link,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    input wire logic device_select_bit2,
    input wire logic device_select_bit1,
    input wire logic device_select_bit0,
    input wire logic [7:0] tx_data,
    output logic tx_taken,
    output two_wire_slave_pkg::rx_byte_s rx,
    output logic rx_valid,
    output logic addressed
);
    import two_wire_slave_pkg::*;

    // ************************************************************
    // Link domain: pin synchronisers
    // ************************************************************
    // Two-stage line samplers; first stage feeds only the second
    line_pair_s line_m;
    line_pair_s line_s;
    line_pair_s line_p; // Previous synchronised sample, for edges
    // Select pins and clock enable brought into the link domain
    logic [2:0] dsel_m;
    logic [2:0] dsel_s;
    logic ce_m;
    logic ce_s;

    // Synchronisers run even while frozen so no stale level waits
    always_ff @(posedge clk_link or negedge nrst) begin
        if (!nrst) begin
            line_m <= '{scl: 1'h1, sda: 1'h1};
            line_s <= '{scl: 1'h1, sda: 1'h1};
            dsel_m <= 3'h0;
            dsel_s <= 3'h0;
            ce_m <= 1'h0;
            ce_s <= 1'h0;
        end else begin
            line_m <= '{scl: scl_in, sda: sda_in};
            line_s <= line_m;
            dsel_m <= {device_select_bit2, device_select_bit1, device_select_bit0};
            dsel_s <= dsel_m;
            ce_m <= ce;
            ce_s <= ce_m;
        end
    end

    // ************************************************************
    // Link domain: condition and edge decode
    // ************************************************************
    // Clock held high in both samples: SDA change is a condition
    wire scl_high = line_s.scl & line_p.scl;
    wire start_det = scl_high & line_p.sda & ~line_s.sda; // Falling SDA under high SCL
    wire stop_det = scl_high & ~line_p.sda & line_s.sda; // Rising SDA under high SCL
    // SCL edges; data is taken on the rise only
    wire scl_rise = line_s.scl & ~line_p.scl;
    wire scl_fall = ~line_s.scl & line_p.scl;
    // Bus free indication, informative only
    wire bus_free = line_s.scl & line_s.sda;

    // ************************************************************
    // Link domain: sequencer registers
    // ************************************************************
    link_state_e state; // Current state of the byte sequencer
    link_state_e next_state;
    logic [3:0] bitcnt; // Bits seen in the current byte
    logic [3:0] next_bitcnt;
    logic [7:0] shreg; // Shift register shared by receive and transmit
    logic [7:0] next_shreg;
    logic drv; // High while the device pulls SDA low
    logic next_drv;
    logic rw; // Latched direction of this transfer
    logic next_rw;
    logic tx_wait; // Waiting for the user side to hand over a byte
    logic next_tx_wait;
    logic first; // Next received byte is the first after the control byte
    logic next_first;
    logic mack; // Master answered the last sent byte with acknowledge
    logic next_mack;
    // Word crossing toward the user side, steady between toggles
    rx_byte_s rx_hold;
    rx_byte_s next_rx_hold;
    logic rx_tgl;
    logic next_rx_tgl;
    logic req_tgl; // Request for a transmit byte, one toggle per byte
    logic next_req_tgl;
    logic ack_tgl; // Acknowledge of a transmit byte from the user side
    logic [2:0] ack_sync;
    logic [7:0] tx_hold; // Transmit byte held on the user side
    // Selection flag, a flop so the crossing never sees a decode glitch
    logic selected;

    // Control byte decode
    wire code_ok = shreg[CTRL_MSB:CTRL_LSB] == CTRL_CODE;
    wire dsel_ok = shreg[DSEL_MSB:DSEL_LSB] == dsel_s;
    wire addr_match = code_ok & dsel_ok;
    wire byte_done = scl_fall & (bitcnt == BITS_PER_BYTE);
    wire ack_edge = ack_sync[2] ^ ack_sync[1];
    wire next_tx_bit = shreg[BYTE_MSB - 1]; // Transmit bit after the current MSB
    // Active transfer with this device, as the next state has it
    wire next_selected = |(next_state & (ST_ACK | ST_RX | ST_TX | ST_MACK));

    // ************************************************************
    // Link domain: next-state logic
    // ************************************************************
    // START and STOP override every state, so framing cannot stick
    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_drv = drv;
        next_rw = rw;
        next_tx_wait = tx_wait;
        next_first = first;
        next_mack = mack;
        next_rx_hold = rx_hold;
        next_rx_tgl = rx_tgl;
        next_req_tgl = req_tgl;
        if (start_det) begin
            // Fresh or repeated START: listen for a control byte
            next_state = ST_ADDR;
            next_bitcnt = BIT_CNT_RST;
            next_drv = 1'h0;
            next_tx_wait = 1'h0;
        end else if (stop_det) begin
            // Transfer over, let go of the line
            next_state = ST_IDLE;
            next_drv = 1'h0;
            next_tx_wait = 1'h0;
        end else begin
            case (state)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        // One bit per clock pulse
                        next_shreg = {shreg[6:0], line_s.sda};
                        next_bitcnt = 4'(bitcnt + 4'h1);
                    end else if (byte_done) begin
                        if (state == ST_RX) begin
                            // Hand the byte over and acknowledge it
                            next_rx_hold = '{data: shreg, first: first};
                            next_rx_tgl = ~rx_tgl;
                            next_first = 1'h0;
                            next_drv = 1'h1;
                            next_state = ST_ACK;
                        end else if (addr_match) begin
                            // Our control byte: acknowledge, note direction
                            next_rw = shreg[RW_BIT];
                            next_first = 1'h1;
                            next_drv = 1'h1;
                            next_state = ST_ACK;
                        end else begin
                            // Someone else's transfer
                            next_state = ST_IGNORE;
                        end
                    end
                end
                ST_ACK: begin
                    // Low held through the whole ninth pulse
                    if (scl_fall) begin
                        next_drv = 1'h0;
                        next_bitcnt = BIT_CNT_RST;
                        if (rw == RW_READ) begin
                            next_req_tgl = ~req_tgl;
                            next_tx_wait = 1'h1;
                            next_state = ST_TX;
                        end else begin
                            next_state = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (tx_wait) begin
                        // Byte arrives while SCL is low after acknowledge
                        if (ack_edge) begin
                            next_shreg = tx_hold;
                            next_drv = ~tx_hold[BYTE_MSB];
                            next_tx_wait = 1'h0;
                        end
                    end else if (scl_rise) begin
                        next_bitcnt = 4'(bitcnt + 4'h1);
                    end else if (byte_done) begin
                        // Free the line for the master's answer
                        next_drv = 1'h0;
                        next_state = ST_MACK;
                    end else if (scl_fall) begin
                        // Change data only while SCL is low
                        next_shreg = {shreg[6:0], 1'h0};
                        next_drv = ~next_tx_bit;
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_mack = ~line_s.sda;
                    end else if (scl_fall) begin
                        if (mack) begin
                            // Master wants more
                            next_bitcnt = BIT_CNT_RST;
                            next_req_tgl = ~req_tgl;
                            next_tx_wait = 1'h1;
                            next_state = ST_TX;
                        end else begin
                            // Last byte: stay released for STOP
                            next_state = ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    next_state = state; // Only a condition leaves these states
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Link domain: sequencer flops
    // ************************************************************
    // Whole sequencer frozen while the enable is low
    always_ff @(posedge clk_link or negedge nrst) begin
        if (!nrst) begin
            line_p <= '{scl: 1'h1, sda: 1'h1};
            state <= ST_IDLE;
            bitcnt <= BIT_CNT_RST;
            shreg <= BYTE_RST;
            drv <= 1'h0;
            rw <= 1'h0;
            tx_wait <= 1'h0;
            first <= 1'h0;
            mack <= 1'h0;
            rx_hold <= '{data: BYTE_RST, first: 1'h0};
            rx_tgl <= 1'h0;
            req_tgl <= 1'h0;
            selected <= 1'h0;
            ack_sync <= 3'h0;
        end else if (ce_s) begin
            line_p <= line_s;
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            drv <= next_drv;
            rw <= next_rw;
            tx_wait <= next_tx_wait;
            first <= next_first;
            mack <= next_mack;
            rx_hold <= next_rx_hold;
            rx_tgl <= next_rx_tgl;
            req_tgl <= next_req_tgl;
            selected <= next_selected;
            ack_sync <= {ack_sync[1:0], ack_tgl}; // Toggle synchroniser plus edge stage
        end
    end

    // Open-drain lines: only pull low or let go
    assign sda_out = 1'h0;
    assign sda_oe = drv;
    // Clock is never driven; it is always the master's
    assign scl_out = 1'h0;
    assign scl_oe = 1'h0;

    // ************************************************************
    // System domain: crossings and user outputs
    // ************************************************************
    // Toggle and level synchronisers, third stage for edges
    logic [2:0] rx_sync;
    logic [2:0] req_sync;
    logic [1:0] sel_sync;
    wire rx_edge = rx_sync[2] ^ rx_sync[1];
    wire req_edge = req_sync[2] ^ req_sync[1];

    // Held words are steady for many link cycles after each toggle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_sync <= 3'h0;
            req_sync <= 3'h0;
            sel_sync <= 2'h0;
            rx <= '{data: BYTE_RST, first: 1'h0};
            rx_valid <= 1'h0;
            tx_hold <= BYTE_RST;
            ack_tgl <= 1'h0;
            tx_taken <= 1'h0;
            addressed <= 1'h0;
        end else if (ce) begin
            rx_sync <= {rx_sync[1:0], rx_tgl};
            req_sync <= {req_sync[1:0], req_tgl};
            sel_sync <= {sel_sync[0], selected};
            addressed <= sel_sync[1];
            rx_valid <= rx_edge;
            tx_taken <= req_edge;
            if (rx_edge) begin
                rx <= rx_hold;
            end
            if (req_edge) begin
                // Take the user byte and answer the request
                tx_hold <= tx_data;
                ack_tgl <= ~ack_tgl;
            end
        end
    end

    wire unused_ok = bus_free; // Bus-free level is informative only

endmodule // two_wire_slave_port

`default_nettype wire

// [design/two_wire_slave_pkg.sv]
// ****************************************************************
// Shared constants and types of the two-wire slave port
// ****************************************************************
package two_wire_slave_pkg;

    // Fixed control code expected in the top nibble; value is arbitrary
    localparam logic [3:0] CTRL_CODE = 4'h6;
    // Control byte field positions
    localparam int CTRL_MSB = 7;
    localparam int CTRL_LSB = 4;
    localparam int DSEL_MSB = 3;
    localparam int DSEL_LSB = 1;
    localparam int RW_BIT = 0;
    // Direction bit value that selects a read
    localparam logic RW_READ = 1'h1;

    // Byte framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam int BYTE_MSB = 7;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Supported bus clock rates in kHz
    localparam int STD_RATE_KHZ = 100;
    localparam int FAST_RATE_KHZ = 400;

    // Link-side sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_ADDR   = 8'h02,
        ST_ACK    = 8'h04,
        ST_RX     = 8'h08,
        ST_TX     = 8'h10,
        ST_MACK   = 8'h20,
        ST_IGNORE = 8'h40
    } link_state_e;

    // Received byte as handed to the user side
    typedef struct packed {
        logic [7:0] data;
        logic first;
    } rx_byte_s;

    // Sampled levels of the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } line_pair_s;

endpackage

// [tb/two_wire_slave_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Port checker
// *****
module two_wire_slave_properties (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_link,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic tx_taken,
    input wire logic rx_valid,
    input wire logic addressed
);
    // Lines only pulled low or left alone
    open_drain_a: assert property (@(posedge clk_sys) disable iff (!nrst) !scl_oe && !sda_out)
        else $error("bus line driven high");
    // Data line moves only while the clock is low
    sda_change_a: assert property (@(posedge clk_link) disable iff (!nrst) $changed(sda_oe) |-> !scl_in)
        else $error("data line moved with clock high");
    // Stop drops the selection within a bound
    stop_release_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        scl_in && $rose(sda_in) |-> ##[1:60] !addressed) else $error("selection kept after stop");
    // Any pull low belongs to a selected transfer
    ack_select_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sda_oe |-> ##[0:60] addressed) else $error("data line pulled while not selected");
    // Each received byte is acknowledged
    rx_ack_a: assert property (@(posedge clk_sys) disable iff (!nrst) rx_valid |-> ##[0:60] sda_oe)
        else $error("byte received without acknowledge");
    // Bytes only flow while selected
    rx_addressed_a: assert property (@(posedge clk_sys) disable iff (!nrst) rx_valid |-> addressed)
        else $error("byte handed out while not selected");
    tx_addressed_a: assert property (@(posedge clk_sys) disable iff (!nrst) tx_taken |-> addressed)
        else $error("byte requested while not selected");
    // Handshake outputs are single pulses
    rx_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst) rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
    tx_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst) tx_taken |=> !tx_taken)
        else $error("send strobe longer than one cycle");
    // Main scenarios reached
    cover property (@(posedge clk_sys) rx_valid);
    cover property (@(posedge clk_sys) tx_taken);
    cover property (@(posedge clk_sys) $fell(addressed));
endmodule // two_wire_slave_properties

bind two_wire_slave_port two_wire_slave_properties props (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .tx_taken(tx_taken), .rx_valid(rx_valid), .addressed(addressed));
`default_nettype wire

// [tb/two_wire_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Bus master model
// *****
module two_wire_master_model (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    int tq = 150; // Quarter clock period, ns
    // Idle: both released, clock still
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Start or repeated start
    task automatic start();
        #tq sda_m = 1'b1;
        #tq scl = 1'b1;
        #tq sda_m = 1'b0;
        #tq scl = 1'b0;
    endtask
    // Stop leaves the clock standing high
    task automatic stop();
        #tq sda_m = 1'b0;
        #tq scl = 1'b1;
        #tq sda_m = 1'b1;
        #tq;
    endtask
    // One bit: set in low phase, read in high phase
    task automatic bit_io(input logic b, output logic s);
        #tq sda_m = b;
        #tq scl = 1'b1;
        #tq s = sda;
        #tq scl = 1'b0;
    endtask
    // Byte then ninth pulse; ack_in low acknowledges a read byte
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack);
    endtask
endmodule // two_wire_master_model
`default_nettype wire

// [tb/two_wire_slave_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Bench
// *****
module two_wire_slave_port_test;
    import two_wire_slave_pkg::*;
    logic clk_sys, clk_link, nrst, ce, scl, sda_m;
    logic scl_out, scl_oe, sda_out, sda_oe, tx_taken, rx_valid, addressed;
    logic [2:0] sel; // Select straps
    logic [7:0] tx_data;
    rx_byte_s rx;
    rx_byte_s rxq[$]; // Bytes handed out
    logic [7:0] txq[$]; // Bytes taken for sending
    int seed, mismatches, n_tests;
    // Wired-AND with pull-ups
    wire logic scl_w = scl & ~(scl_oe & ~scl_out);
    wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
    two_wire_slave_port dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .clk_link(clk_link), .scl_in(scl_w),
        .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .device_select_bit2(sel[2]), .device_select_bit1(sel[1]), .device_select_bit0(sel[0]),
        .tx_data(tx_data), .tx_taken(tx_taken), .rx(rx), .rx_valid(rx_valid), .addressed(addressed));
    two_wire_master_model master (.scl(scl), .sda_m(sda_m), .sda(sda_w));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Link clock, phase unrelated
    initial begin
        clk_link = 1'b0;
        #3.3;
        forever #7.5 clk_link = ~clk_link;
    end
    // Capture away from the launching edge
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx);
        end
        if (tx_taken === 1'b1) begin
            txq.push_back(tx_data);
            tx_data = 8'($random(seed));
        end
    end
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] ctrl(input logic [3:0] code, input logic [2:0] s, input logic rw);
        return {code, s, rw};
    endfunction
    // Control byte and its expected answer
    task automatic addr(input logic [3:0] code, input logic [2:0] s, input logic rw, input logic hit);
        logic [7:0] q;
        logic a;
        master.start();
        master.xfer(ctrl(code, s, rw), 1'b1, q, a);
        chk_bit("control ack", ~hit, a);
        chk_bit("addressed", hit, addressed);
        chk_bit("clock pin", 1'b0, scl_oe | scl_out);
    endtask
    // Write bytes, compare what the user side saw
    task automatic wr(input int n, input logic hit);
        logic [7:0] d, q;
        logic a;
        rx_byte_s r;
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            master.xfer(d, 1'b1, q, a);
            chk_bit("data ack", ~hit, a);
            chk_bit("rx count", hit, rxq.size() > 0);
            if (rxq.size() > 0) begin
                r = rxq.pop_front();
                chk_byte("rx data", d, r.data);
                chk_bit("rx first", i == 0, r.first);
            end
        end
    endtask
    // Read bytes; last one not acknowledged
    task automatic rd(input int n);
        logic [7:0] q;
        logic a;
        for (int i = 0; i < n; i++) begin
            master.xfer(8'hff, i == n - 1, q, a);
            chk_bit("tx request", 1'b1, txq.size() > 0);
            if (txq.size() > 0) begin
                chk_byte("tx data", txq.pop_front(), q);
            end
        end
        #300;
        chk_bit("released after nack", 1'b1, sda_w);
        chk_bit("no extra request", 1'b0, txq.size() > 0);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #395000;
        mismatches++;
        close_out();
    end
    initial begin
        seed = 30170;
        mismatches = 0;
        n_tests = 0;
        nrst = 1'b0;
        ce = 1'b1;
        sel = 3'h0;
        tx_data = 8'($random(seed));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) nrst = 1'b1;
        #100;
        // Every strap setting
        for (int s = 0; s < 8; s++) begin
            @(negedge clk_sys) sel = 3'(s);
            #100;
            addr(CTRL_CODE, sel, 1'b0, 1'b1);
            wr(2, 1'b1);
            master.stop();
            #51;
            chk_bit("addressed after stop", 1'b0, addressed);
        end
        addr(CTRL_CODE, sel, RW_READ, 1'b1);
        rd(3);
        master.stop();
        // Wrong select, then wrong code
        addr(CTRL_CODE, sel ^ 3'h1, 1'b0, 1'b0);
        wr(1, 1'b0);
        addr(CTRL_CODE ^ 4'h8, sel, 1'b0, 1'b0);
        // Repeated starts switch direction
        addr(CTRL_CODE, sel, 1'b0, 1'b1);
        wr(1, 1'b1);
        addr(CTRL_CODE, sel, RW_READ, 1'b1);
        rd(1);
        master.stop();
        // Fast and standard rates
        master.tq = 625;
        addr(CTRL_CODE, sel, 1'b0, 1'b1);
        wr(1, 1'b1);
        master.tq = 2500;
        addr(CTRL_CODE, sel, 1'b0, 1'b1);
        master.stop();
        close_out();
    end
endmodule // two_wire_slave_port_test
`default_nettype wire
